// ### verilog/vla_top.sv
// level adjust and per-line data type control with two-wire register access
// assumes scl/sda and all video inputs are synchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
module vla_top #(
    parameter logic [6:0] DEV_ADDR = vla_pkg::DEF_BUS_ADDR
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic field_start,
    input wire logic line_start,
    input wire logic field_odd_in,
    input wire logic pseudo_sync_detect,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [vla_pkg::DATA_W-1:0] in_data,
    input wire logic in_is_chroma,
    output logic out_valid,
    input wire logic out_ready,
    output logic [vla_pkg::DATA_W-1:0] out_data,
    output logic raw_data_indicator,
    output logic blanking_data_indicator
);
    import vla_pkg::*;

    logic [7:0] contrast_setting;
    logic [7:0] brightness_setting;
    logic [7:0] saturation_setting;
    logic [7:0] raw_gain_setting;
    logic [7:0] raw_offset_setting;
    logic [7:0] line_type_index [LINE_IDX_FIRST:LINE_IDX_REST];
    logic [7:0] vertical_offset_low;
    logic [7:0] vertical_offset_high_field_offset;
    logic copy_protect_flag;

    vla_bus_state_type bus_state;
    logic scl_q;
    logic sda_q;
    logic [2:0] bit_cnt;
    logic seen_rise;
    logic ack_phase;
    logic [7:0] shift;
    logic [7:0] sub_addr;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;
    logic byte_done;

    logic [9:0] line_cnt;
    logic field_is_odd;
    logic [8:0] vertical_line_offset;
    logic field_offset_bit;
    logic [3:0] line_kind;
    logic comp_line;

    vla_kind_type sample_kind;
    logic calc_valid;
    logic [7:0] calc_data;

    vla_stream_if #(.WIDTH(DATA_W)) fill_bus ();
    vla_stream_if #(.WIDTH(DATA_W)) drain_bus ();

    // two-wire bus framing
    assign start_cond = scl_in && scl_q && sda_q && !sda_in;
    assign stop_cond = scl_in && scl_q && !sda_q && sda_in;
    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign byte_done = seen_rise && (bit_cnt == 3'd0);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // open drain: the pin is only ever pulled low
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    function automatic logic [7:0] read_reg(input logic [7:0] addr);
        logic [7:0] val;
        val = 8'h00;
        if (addr >= OFF_LINE_FIRST && addr <= OFF_LINE_LAST) begin
            val = line_type_index[5'(addr - OFF_LINE_FIRST) + 5'(LINE_IDX_FIRST)];
        end else begin
            unique case (addr)
                OFF_STATUS: begin
                    val[COPY_FLAG_BIT] = copy_protect_flag;
                    val[FIELD_ODD_BIT] = field_is_odd;
                end
                OFF_VERTICAL_LINE_OFFSET_LOW: val = vertical_offset_low;
                OFF_VERTICAL_LINE_OFFSET_HIGH: val = vertical_offset_high_field_offset;
                OFF_BRIGHT: val = brightness_setting;
                OFF_CONTRAST: val = contrast_setting;
                OFF_SAT: val = saturation_setting;
                OFF_RAW_GAIN: val = raw_gain_setting;
                OFF_RAW_OFFSET: val = raw_offset_setting;
                default: val = 8'h00;
            endcase
        end
        return val;
    endfunction : read_reg

    always_comb begin
        rd_data = read_reg(sub_addr);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_state <= BUS_IDLE;
            bit_cnt <= 3'd0;
            seen_rise <= 1'b0;
            ack_phase <= 1'b0;
            shift <= 8'h00;
            sub_addr <= 8'h00;
            sda_oe <= 1'b0;
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_en <= 1'b0;
            if (start_cond) begin
                bus_state <= BUS_ADDR;
                bit_cnt <= 3'd0;
                seen_rise <= 1'b0;
                ack_phase <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_cond) begin
                bus_state <= BUS_IDLE;
                sda_oe <= 1'b0;
                ack_phase <= 1'b0;
            end else if (bus_state != BUS_IDLE && scl_rise) begin
                if (ack_phase) begin
                    // a master nack ends a read burst
                    if (bus_state == BUS_READ && sda_in) begin
                        bus_state <= BUS_IDLE;
                    end
                end else begin
                    bit_cnt <= bit_cnt + 3'd1;
                    seen_rise <= 1'b1;
                    if (bus_state != BUS_READ) begin
                        shift <= {shift[6:0], sda_in};
                    end
                end
            end else if (bus_state != BUS_IDLE && scl_fall) begin
                if (ack_phase) begin
                    ack_phase <= 1'b0;
                    sda_oe <= 1'b0;
                    if (bus_state == BUS_ADDR) begin
                        bus_state <= shift[0] ? BUS_READ : BUS_SUB;
                    end else if (bus_state == BUS_SUB) begin
                        bus_state <= BUS_WRITE;
                    end
                    if (bus_state == BUS_READ || (bus_state == BUS_ADDR && shift[0])) begin
                        sda_oe <= !rd_data[7];
                        shift <= {rd_data[6:0], 1'b0};
                        sub_addr <= sub_addr + 8'h01;
                    end
                end else if (byte_done) begin
                    seen_rise <= 1'b0;
                    ack_phase <= 1'b1;
                    unique case (bus_state)
                        BUS_ADDR: begin
                            if (shift[7:1] == DEV_ADDR) begin
                                sda_oe <= 1'b1;
                            end else begin
                                bus_state <= BUS_IDLE;
                                ack_phase <= 1'b0;
                            end
                        end
                        BUS_SUB: begin
                            sub_addr <= shift;
                            sda_oe <= 1'b1;
                        end
                        BUS_WRITE: begin
                            wr_en <= 1'b1;
                            wr_addr <= sub_addr;
                            wr_data <= shift;
                            sub_addr <= sub_addr + 8'h01;
                            sda_oe <= 1'b1;
                        end
                        BUS_READ: sda_oe <= 1'b0;
                        default: bus_state <= BUS_IDLE;
                    endcase
                end else if (bus_state == BUS_READ && seen_rise) begin
                    sda_oe <= !shift[7];
                    shift <= {shift[6:0], 1'b0};
                end
            end
        end
    end

    // register file
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            contrast_setting <= RST_CONTRAST;
            brightness_setting <= RST_BRIGHT;
            saturation_setting <= RST_SAT;
            raw_gain_setting <= RST_RAW_GAIN;
            raw_offset_setting <= RST_RAW_OFFSET;
            vertical_offset_low <= RST_VERTICAL_LINE_OFFSET_LOW;
            vertical_offset_high_field_offset <= RST_VERTICAL_LINE_OFFSET_HIGH;
        end else if (wr_en) begin
            unique case (wr_addr)
                OFF_CONTRAST: contrast_setting <= wr_data;
                OFF_BRIGHT: brightness_setting <= wr_data;
                OFF_SAT: saturation_setting <= wr_data;
                OFF_RAW_GAIN: raw_gain_setting <= wr_data;
                OFF_RAW_OFFSET: raw_offset_setting <= wr_data;
                OFF_VERTICAL_LINE_OFFSET_LOW: vertical_offset_low <= wr_data;
                OFF_VERTICAL_LINE_OFFSET_HIGH: vertical_offset_high_field_offset <= wr_data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = LINE_IDX_FIRST; i <= LINE_IDX_REST; i++) begin
                line_type_index[i] <= RST_LINE_TYPE;
            end
        end else if (wr_en && wr_addr >= OFF_LINE_FIRST && wr_addr <= OFF_LINE_LAST) begin
            line_type_index[5'(wr_addr - OFF_LINE_FIRST) + 5'(LINE_IDX_FIRST)] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            copy_protect_flag <= 1'b0;
        end else begin
            copy_protect_flag <= pseudo_sync_detect;
        end
    end

    assign vertical_line_offset = {vertical_offset_high_field_offset[VOFF8_BIT],
                                   vertical_offset_low};
    assign field_offset_bit = vertical_offset_high_field_offset[FIELD_OFFSET_BIT_BIT];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            line_cnt <= LINE_CNT_START;
            field_is_odd <= 1'b1;
        end else if (field_start) begin
            line_cnt <= LINE_CNT_START;
            field_is_odd <= field_odd_in ^ field_offset_bit;
        end else if (line_start && line_cnt != LINE_CNT_MAX) begin
            line_cnt <= line_cnt + 10'd1;
        end
    end

    always_comb begin
        logic signed [10:0] idx;
        logic [7:0] entry;
        entry = line_type_index[LINE_IDX_REST];
        idx = $signed({1'b0, line_cnt}) - $signed({2'b00, vertical_line_offset});
        if (idx >= 11'sd2 && idx <= 11'sd23) begin
            entry = line_type_index[5'(idx)];
        end
        line_kind = field_is_odd ? entry[7:4] : entry[3:0];
        comp_line = (line_kind == TYPE_COMP_BLANK) || (line_kind == TYPE_COMP_ACTIVE);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            raw_data_indicator <= 1'b0;
            blanking_data_indicator <= 1'b0;
        end else begin
            raw_data_indicator <= !comp_line;
            blanking_data_indicator <= (line_kind != TYPE_COMP_ACTIVE);
        end
    end

    always_comb begin
        if (!comp_line) begin
            sample_kind = KIND_RAW;
        end else if (in_is_chroma) begin
            sample_kind = KIND_CHROMA;
        end else begin
            sample_kind = KIND_LUMA;
        end
    end

    // fifo ready keeps a spare slot, so the arithmetic stage never has to stall
    vla_level_calc u_calc (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(in_valid && in_ready),
        .in_data(in_data),
        .in_kind(sample_kind),
        .contrast_setting(contrast_setting),
        .brightness_setting(brightness_setting),
        .saturation_setting(saturation_setting),
        .raw_gain_setting(raw_gain_setting),
        .raw_offset_setting(raw_offset_setting),
        .out_valid(calc_valid),
        .out_data(calc_data)
    );

    assign fill_bus.valid = calc_valid;
    assign fill_bus.data = calc_data;
    assign in_ready = fill_bus.ready;
    assign drain_bus.ready = out_ready;
    assign out_valid = drain_bus.valid;
    assign out_data = drain_bus.data;

    vla_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .fill(fill_bus.snk),
        .drain(drain_bus.src)
    );
endmodule : vla_top
`default_nettype wire

// ### common/vla_pkg.sv
// constants and types shared by the video level adjust and line type block
// assumes the two-wire control bus and the line-locked clock come from outside
//
// Contract
// - luminance out is Int(contrast/68 * (y - 128)) plus brightness
// - colour difference out is Int(saturation/64 * (c - 128)) plus 128
// - raw out is Int(raw gain/64 * (sample - 128)) plus raw offset
// - every result is clamped to the range 1 to 254
// - contrast resets to 44h, brightness 80h, saturation 40h, eight bits each
// - raw gain resets to 64, raw offset to 128, eight bits each
// - line indices 2 to 23 each carry their own data type
// - index 24 data type applies to all remaining lines of the field
// - upper nibble serves the odd field, lower nibble the even field
// - line to index mapping shifted by nine-bit offset and field offset bit
// - codes 6 and 15 give component 4:2:2, all other codes give raw
// - raw and blanking indicators decode from the current line's data type
// - pseudo sync detection shows as a flag in status byte 1Fh
package vla_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 32;

    localparam logic [7:0] OFF_STATUS = 8'h1f;
    localparam logic [7:0] OFF_LINE_FIRST = 8'h41;
    localparam logic [7:0] OFF_LINE_LAST = 8'h57;
    localparam logic [7:0] OFF_VERTICAL_LINE_OFFSET_LOW = 8'h5a;
    localparam logic [7:0] OFF_VERTICAL_LINE_OFFSET_HIGH = 8'h5b;
    localparam logic [7:0] OFF_BRIGHT = 8'h20;
    localparam logic [7:0] OFF_CONTRAST = 8'h21;
    localparam logic [7:0] OFF_SAT = 8'h22;
    localparam logic [7:0] OFF_RAW_GAIN = 8'h23;
    localparam logic [7:0] OFF_RAW_OFFSET = 8'h24;

    localparam logic [7:0] RST_CONTRAST = 8'h44;
    localparam logic [7:0] RST_BRIGHT = 8'h80;
    localparam logic [7:0] RST_SAT = 8'h40;
    localparam logic [7:0] RST_RAW_GAIN = 8'h40;
    localparam logic [7:0] RST_RAW_OFFSET = 8'h80;
    localparam logic [7:0] RST_LINE_TYPE = 8'hff;
    localparam logic [7:0] RST_VERTICAL_LINE_OFFSET_LOW = 8'h03;
    localparam logic [7:0] RST_VERTICAL_LINE_OFFSET_HIGH = 8'h00;

    localparam int FIELD_OFFSET_BIT_BIT = 7;
    localparam int VOFF8_BIT = 4;
    localparam int COPY_FLAG_BIT = 6;
    localparam int FIELD_ODD_BIT = 0;

    localparam int LINE_IDX_FIRST = 2;
    localparam int LINE_IDX_LAST = 23;
    localparam int LINE_IDX_REST = 24;
    localparam logic [9:0] LINE_CNT_START = 10'h000;
    localparam logic [9:0] LINE_CNT_MAX = 10'h3ff;

    localparam logic [3:0] TYPE_COMP_BLANK = 4'h6;
    localparam logic [3:0] TYPE_COMP_ACTIVE = 4'hf;

    localparam logic signed [18:0] DIV_LUMA = 19'sh00044;
    localparam logic signed [18:0] DIV_CHROMA = 19'sh00040;
    localparam logic signed [18:0] DIV_RAW = 19'sh00040;
    localparam logic [7:0] MID_LEVEL = 8'h80;
    localparam logic [7:0] CLIP_MIN = 8'h01;
    localparam logic [7:0] CLIP_MAX = 8'hfe;

    localparam logic [6:0] DEF_BUS_ADDR = 7'h21;

    typedef enum logic [1:0] {KIND_LUMA, KIND_CHROMA, KIND_RAW} vla_kind_type;
    typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_SUB, BUS_WRITE, BUS_READ} vla_bus_state_type;
endpackage : vla_pkg

// ### common/vla_stream_if.sv
// valid/ready sample stream between the block's own modules
// assumes one clock for both ends
`timescale 1ns/100ps
`default_nettype none
interface vla_stream_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : vla_stream_if
`default_nettype wire

// ### verilog/vla_level_calc.sv
// one-stage level arithmetic for luminance, colour difference and raw samples
// assumes settings are stable registers; no stall, the consumer keeps room
`timescale 1ns/100ps
`default_nettype none
module vla_level_calc (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    input wire vla_pkg::vla_kind_type in_kind,
    input wire logic [7:0] contrast_setting,
    input wire logic [7:0] brightness_setting,
    input wire logic [7:0] saturation_setting,
    input wire logic [7:0] raw_gain_setting,
    input wire logic [7:0] raw_offset_setting,
    output logic out_valid,
    output logic [7:0] out_data
);
    import vla_pkg::*;

    // 19-bit product and 20-bit sum cannot wrap for any 8-bit operands
    function automatic logic [7:0] adjust(input logic [7:0] gain, input logic [7:0] smp,
                                          input logic [7:0] offs,
                                          input logic signed [18:0] div);
        logic signed [9:0] diff;
        logic signed [18:0] prod;
        logic signed [18:0] quo;
        logic signed [19:0] sum;
        diff = $signed({2'b00, smp}) - $signed({2'b00, MID_LEVEL});
        prod = $signed({1'b0, gain}) * diff;
        // signed division truncates toward zero
        quo = prod / div;
        sum = 20'(quo) + $signed({12'h000, offs});
        if (sum < $signed({12'h000, CLIP_MIN})) begin
            adjust = CLIP_MIN;
        end else if (sum > $signed({12'h000, CLIP_MAX})) begin
            adjust = CLIP_MAX;
        end else begin
            adjust = sum[7:0];
        end
    endfunction : adjust

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= in_valid;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_data <= 8'h00;
        end else if (in_valid) begin
            unique case (in_kind)
                KIND_LUMA: out_data <= adjust(contrast_setting, in_data, brightness_setting,
                                              DIV_LUMA);
                KIND_CHROMA: out_data <= adjust(saturation_setting, in_data, MID_LEVEL,
                                                DIV_CHROMA);
                KIND_RAW: out_data <= adjust(raw_gain_setting, in_data, raw_offset_setting,
                                             DIV_RAW);
                default: out_data <= CLIP_MIN;
            endcase
        end
    end
endmodule : vla_level_calc
`default_nettype wire

// ### verilog/vla_fifo.sv
// sample FIFO with registered output and registered fill-side ready
// assumes DEPTH is a power of two; ready keeps one spare slot for a pipeline stage
`timescale 1ns/100ps
`default_nettype none
module vla_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    vla_stream_if.snk fill,
    vla_stream_if.src drain
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
    localparam logic [AW:0] READY_MAX = (AW + 1)'(DEPTH - 2);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic do_write;
    logic do_read;

    // full is honest: a write into a full store is dropped, never overwrites
    assign do_write = fill.valid && (count != DEPTH_C);
    assign do_read = (count != '0) && (!drain.valid || drain.ready);
    assign next_count = count + {{AW{1'b0}}, do_write} - {{AW{1'b0}}, do_read};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count <= '0;
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            count <= next_count;
            if (do_write) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_read) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (do_write) begin
            mem[wr_ptr] <= fill.data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fill.ready <= 1'b1;
        end else begin
            fill.ready <= (next_count <= READY_MAX);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            drain.valid <= 1'b0;
            drain.data <= '0;
        end else if (do_read) begin
            drain.valid <= 1'b1;
            drain.data <= mem[rd_ptr];
        end else if (drain.ready) begin
            drain.valid <= 1'b0;
        end
    end
endmodule : vla_fifo
`default_nettype wire

// ### sim/vla_sink_model.sv
// sink standing in for the scaler and slicer side of the output stream
// assumes the block's clock; with stall high it takes every other cycle
`timescale 1ns/100ps
`default_nettype none
module vla_sink_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic stall,
    output logic out_ready
);
    always_ff @(posedge ref_clk) begin
        out_ready <= rst | !stall | !out_ready;
    end
endmodule : vla_sink_model
`default_nettype wire

// ### sim/vla_top_properties.sv
// port properties of the level adjust block
// assumes it is bound onto vla_top
`timescale 1ns/100ps
`default_nettype none
module vla_top_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [vla_pkg::DATA_W-1:0] out_data,
    input wire logic raw_data_indicator,
    input wire logic blanking_data_indicator
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // samples inside the block, so no output appears without a cause
    logic [7:0] pending;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pending <= 8'h00;
        end else begin
            pending <= pending + 8'(in_valid && in_ready) - 8'(out_valid && out_ready);
        end
    end
    chk_out_range: assert property (out_valid |-> out_data >= 8'h01 && out_data <= 8'hfe)
        else $error("output sample outside 1..254");
    chk_hold_valid: assert property (out_valid && !out_ready |=> out_valid)
        else $error("output valid dropped before taken");
    chk_hold_data: assert property (out_valid && !out_ready |=> $stable(out_data))
        else $error("output data changed while stalled");
    chk_raw_blank: assert property (raw_data_indicator |-> blanking_data_indicator)
        else $error("raw line not flagged as blanking data");
    chk_sda_open: assert property (sda_oe |-> !sda_out)
        else $error("data pin driven high");
    chk_reset_state: assert property ($fell(rst) |-> !out_valid && !sda_oe && in_ready)
        else $error("outputs wrong after reset");
    chk_take_answer: assert property (in_valid && in_ready |-> ##[1:100] out_valid)
        else $error("taken sample never answered");
    chk_out_cause: assert property (out_valid |-> pending != 8'h00)
        else $error("output with no sample pending");
endmodule : vla_top_properties
bind vla_top vla_top_properties chk_i (.ref_clk, .rst, .sda_out, .sda_oe, .in_valid, .in_ready,
    .out_valid, .out_ready, .out_data, .raw_data_indicator, .blanking_data_indicator);
`default_nettype wire

// ### sim/vla_top_tb_top.sv
// bench for the level adjust block: registers, arithmetic, line types
// assumes the sink model stalls the output stream throughout
`timescale 1ns/100ps
`default_nettype none
module vla_top_tb_top;
    import vla_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, scl = 1'b1, sda_m = 1'b1, fs = 1'b0, ls = 1'b0;
    logic odd = 1'b1, psd = 1'b0, iv = 1'b0, chroma = 1'b0, stall = 1'b1;
    logic sda_out, sda_oe, in_ready, ov, ordy, rawi, blanki;
    logic [7:0] id = 8'h00, od;
    int err_count = 0, comparisons = 0, cyc = 0;
    wire sda_in = sda_m & !sda_oe;
    always #50 ref_clk = ~ref_clk;
    vla_top dut (.ref_clk, .rst, .scl_in(scl), .sda_in, .sda_out, .sda_oe, .field_start(fs),
        .line_start(ls), .field_odd_in(odd), .pseudo_sync_detect(psd), .in_valid(iv),
        .in_ready, .in_data(id), .in_is_chroma(chroma), .out_valid(ov), .out_ready(ordy),
        .out_data(od), .raw_data_indicator(rawi), .blanking_data_indicator(blanki));
    vla_sink_model sink (.ref_clk, .rst, .stall, .out_ready(ordy));
    task automatic chk(string what, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    task automatic bit_io(logic b, output logic s);
        tick(1);
        sda_m <= b;
        tick(3);
        scl <= 1'b1;
        tick(2);
        s = sda_in;
        tick(2);
        scl <= 1'b0;
    endtask : bit_io
    task automatic xfer(logic [7:0] b, logic mack, logic want, output logic [7:0] r);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
            r[i] = s;
        end
        bit_io(mack, s);
        chk("ack slot", {7'h00, want}, {7'h00, s});
    endtask : xfer
    task automatic start_c;
        sda_m <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(3);
        sda_m <= 1'b0;
        tick(3);
        scl <= 1'b0;
    endtask : start_c
    task automatic stop_c;
        tick(1);
        sda_m <= 1'b0;
        tick(3);
        scl <= 1'b1;
        tick(3);
        sda_m <= 1'b1;
        tick(5);
    endtask : stop_c
    task automatic wr(logic [7:0] sub, logic [7:0] d);
        logic [7:0] r;
        start_c();
        xfer({DEF_BUS_ADDR, 1'b0}, 1'b1, 1'b0, r);
        xfer(sub, 1'b1, 1'b0, r);
        xfer(d, 1'b1, 1'b0, r);
        stop_c();
    endtask : wr
    task automatic rd(logic [7:0] sub, output logic [7:0] d);
        logic [7:0] r;
        start_c();
        xfer({DEF_BUS_ADDR, 1'b0}, 1'b1, 1'b0, r);
        xfer(sub, 1'b1, 1'b0, r);
        start_c();
        xfer({DEF_BUS_ADDR, 1'b1}, 1'b1, 1'b0, r);
        xfer(8'hff, 1'b1, 1'b1, d);
        stop_c();
    endtask : rd
    function automatic logic [7:0] lvl(logic [7:0] g, int dv, logic [7:0] off, logic [7:0] s);
        int v = (int'(g) * (int'(s) - 128)) / dv + int'(off);
        return (v < 1) ? 8'h01 : (v > 254) ? 8'hfe : 8'(v);
    endfunction : lvl
    task automatic smp(logic c, logic [7:0] d, logic [7:0] e);
        int n = 0;
        chroma <= c;
        id <= d;
        iv <= 1'b1;
        @(posedge ref_clk);
        iv <= 1'b0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (!(ov === 1'b1 && ordy === 1'b1) && n < 60);
        chk("sample out", e, od);
        @(posedge ref_clk);
    endtask : smp
    task automatic field(logic o, int lines);
        odd <= o;
        fs <= 1'b1;
        tick(1);
        fs <= 1'b0;
        repeat (lines) begin
            ls <= 1'b1;
            tick(1);
            ls <= 1'b0;
            tick(1);
        end
        tick(3);
    endtask : field
    task automatic t_regs;
        logic [7:0] r;
        logic [7:0] e [5] = '{8'h80, 8'h44, 8'h40, 8'h40, 8'h80};
        for (int i = 0; i < 5; i++) begin
            rd(OFF_BRIGHT + 8'(i), r);
            chk("setting reset", e[i], r);
        end
        rd(8'h30, r);
        chk("unmapped read", 8'h00, r);
        psd <= 1'b1;
        rd(OFF_STATUS, r);
        chk("copy flag", 8'h40, r & 8'h40);
        $display("test regs done");
    endtask : t_regs
    task automatic t_arith;
        logic [7:0] ys [4] = '{8'h00, 8'hff, 8'h82, 8'h10};
        wr(OFF_CONTRAST, 8'hff);
        wr(OFF_SAT, 8'h80);
        foreach (ys[i]) begin
            smp(1'b0, ys[i], lvl(8'hff, 68, 8'h80, ys[i]));
            smp(1'b1, ys[i], lvl(8'h80, 64, 8'h80, ys[i]));
        end
        $display("test arith done");
    endtask : t_arith
    task automatic t_lines;
        wr(OFF_LINE_FIRST, 8'h06);
        wr(OFF_RAW_OFFSET, 8'h10);
        field(1'b1, 5);
        chk("odd raw line", 8'h03, {6'h00, rawi, blanki});
        smp(1'b0, 8'hc8, lvl(8'h40, 64, 8'h10, 8'hc8));
        field(1'b0, 5);
        chk("even blank line", 8'h01, {6'h00, rawi, blanki});
        field(1'b0, 30);
        chk("rest of field", 8'h00, {6'h00, rawi, blanki});
        wr(OFF_LINE_LAST, 8'h07);
        tick(2);
        chk("rest raw", 8'h03, {6'h00, rawi, blanki});
        wr(OFF_VERTICAL_LINE_OFFSET_LOW, 8'h02);
        field(1'b0, 4);
        chk("moved offset", 8'h01, {6'h00, rawi, blanki});
        wr(OFF_VERTICAL_LINE_OFFSET_HIGH, 8'h80);
        field(1'b1, 4);
        chk("field offset", 8'h01, {6'h00, rawi, blanki});
        $display("test lines done");
    endtask : t_lines
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    // ceiling well above the roughly four thousand cycles the tests need
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        tick(10);
        rst <= 1'b0;
        tick(2);
        t_regs();
        t_arith();
        t_lines();
        summarize();
    end
endmodule : vla_top_tb_top
`default_nettype wire
